// File: include/boot_strap_pkg.sv
package boot_strap_pkg;
    localparam int BOOT_W = 8;
    localparam int OTHER_W = 8;
    localparam logic [BOOT_W-1:0] PULL_DOWN_ALL = 8'hFF;
    localparam logic [BOOT_W-1:0] CAPTURE_RST = 8'h00;
    localparam logic [BOOT_W-1:0] PULL_UP_NONE = 8'h00;
    localparam logic [2:0] SYNC_RST = 3'h0;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_POR = 2'b01,
        ST_WARM = 2'b10
    } phase_e;

    typedef struct packed {
        logic por_n;
        logic warm_n;
        logic test_rst;
    } reset_in_s;

    typedef struct packed {
        phase_e phase;
        logic qualified;
        logic [BOOT_W-1:0] pull_direction_select;
        logic [BOOT_W-1:0] boot_mode_capture;
        logic capture_valid;
        logic [OTHER_W-1:0] other_pulldown_en;
        logic in_reset;
        logic [BOOT_W-1:0] boot_pulldown_en;
        logic [BOOT_W-1:0] boot_pullup_en;
    } latch_state_s;
endpackage : boot_strap_pkg

// File: rtl/strap_sync.sv
`timescale 1ns/1ps
`default_nettype none
module strap_sync
    import boot_strap_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                    s3_reg[i] <= 1'b0;
                    out_reg[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= din[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    // change accepted once second and third stages agree
                    if (s2_reg[i] == s3_reg[i]) begin
                        out_reg[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate
    assign dout = out_reg;
endmodule : strap_sync
`default_nettype wire

// File: rtl/boot_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none
module boot_strap_latch
    import boot_strap_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic por_req_n,
    input wire logic warm_req_n,
    input wire logic test_rst,
    input wire logic [BOOT_W-1:0] boot_pin,
    output logic [BOOT_W-1:0] boot_pulldown_en,
    output logic [BOOT_W-1:0] boot_pullup_en,
    output logic [OTHER_W-1:0] other_pulldown_en,
    output logic [BOOT_W-1:0] boot_mode_capture,
    output logic capture_valid,
    output logic in_reset
);
    reset_in_s rin;
    logic [2:0] rin_raw;
    logic [2:0] rin_sync;
    logic [BOOT_W-1:0] pins_sync;
    latch_state_s st_reg;
    latch_state_s st_next;

    assign rin_raw = {por_req_n, warm_req_n, test_rst};

    strap_sync #(.W(3)) u_rst_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .din(rin_raw),
        .dout(rin_sync)
    );

    strap_sync #(.W(BOOT_W)) u_pin_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .din(boot_pin),
        .dout(pins_sync)
    );

    // synchroniser outputs reset low, so power-on is seen until inputs settle
    assign rin = reset_in_s'(rin_sync);

    // power-on phase overrides whatever the select register holds
    function automatic logic in_power_on(input phase_e ph);
        return ph == ST_POR;
    endfunction : in_power_on

    always_comb begin
        st_next = st_reg;
        case (st_reg.phase)
            ST_RUN: begin
                if (!rin.por_n) begin
                    st_next.phase = ST_POR;
                    st_next.qualified = !rin.test_rst;
                end else if (!rin.warm_n) begin
                    st_next.phase = ST_WARM;
                end
            end
            ST_POR: begin
                if (rin.test_rst) begin
                    st_next.qualified = 1'b0;
                end
                if (rin.por_n) begin
                    st_next.phase = ST_RUN;
                    if (st_reg.qualified && !rin.test_rst) begin
                        st_next.boot_mode_capture = pins_sync;
                        st_next.capture_valid = 1'b1;
                    end
                    st_next.pull_direction_select = PULL_DOWN_ALL;
                end
            end
            ST_WARM: begin
                // capture untouched on warm reset
                if (!rin.por_n) begin
                    st_next.phase = ST_POR;
                    st_next.qualified = !rin.test_rst;
                end else if (rin.warm_n) begin
                    st_next.phase = ST_RUN;
                end
            end
            default: begin
                st_next.phase = ST_POR;
            end
        endcase
        st_next.in_reset = (st_next.phase != ST_RUN);
        st_next.other_pulldown_en = {OTHER_W{st_next.in_reset}};
        if (in_power_on(st_next.phase)) begin
            st_next.boot_pulldown_en = PULL_DOWN_ALL;
            st_next.boot_pullup_en = PULL_UP_NONE;
        end else begin
            // bit set selects pulldown, cleared selects pullup
            st_next.boot_pulldown_en = st_next.pull_direction_select;
            st_next.boot_pullup_en = ~st_next.pull_direction_select;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.phase <= ST_POR;
            // power-up is itself a power-on entry with test reset low
            st_reg.qualified <= 1'b1;
            st_reg.pull_direction_select <= PULL_DOWN_ALL;
            st_reg.boot_mode_capture <= CAPTURE_RST;
            st_reg.capture_valid <= 1'b0;
            st_reg.other_pulldown_en <= {OTHER_W{1'b1}};
            st_reg.in_reset <= 1'b1;
            st_reg.boot_pulldown_en <= PULL_DOWN_ALL;
            st_reg.boot_pullup_en <= PULL_UP_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign boot_pulldown_en = st_reg.boot_pulldown_en;
    assign boot_pullup_en = st_reg.boot_pullup_en;
    assign other_pulldown_en = st_reg.other_pulldown_en;
    assign boot_mode_capture = st_reg.boot_mode_capture;
    assign capture_valid = st_reg.capture_valid;
    assign in_reset = st_reg.in_reset;

    sequence s_por_exit;
        $past(st_reg.phase) == ST_POR && st_reg.phase == ST_RUN;
    endsequence

    sequence s_por_entry;
        $past(st_reg.phase) != ST_POR && st_reg.phase == ST_POR;
    endsequence

    sequence s_warm_exit;
        $past(st_reg.phase) == ST_WARM && st_reg.phase == ST_RUN;
    endsequence

    AST_POR_PULLDOWN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_POR |-> boot_pulldown_en == PULL_DOWN_ALL && boot_pullup_en == 8'h00)
        else $error("boot pins not pulled down in power-on reset");
    AST_INIT_SELECT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_por_exit |-> st_reg.pull_direction_select == PULL_DOWN_ALL)
        else $error("pull select not initialised at release");
    AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_POR && rin.por_n && st_reg.qualified && !rin.test_rst
        |=> boot_mode_capture == $past(pins_sync) && capture_valid)
        else $error("pins not captured at power-on exit");
    AST_TRST_BLOCK: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_POR && rin.test_rst |=> $stable(boot_mode_capture))
        else $error("capture changed with test reset high");
    AST_WARM_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_WARM |=> $stable(boot_mode_capture) && $stable(capture_valid))
        else $error("warm reset altered capture");
    AST_OTHER_PD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        in_reset |-> other_pulldown_en == 8'hFF)
        else $error("other pins not pulled down in reset");
    AST_SECOND_POR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_por_entry ##1 st_reg.phase == ST_POR |-> boot_pulldown_en == PULL_DOWN_ALL)
        else $error("second power-on lost pulldowns");
    AST_HOLD_RUN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_RUN && $past(st_reg.phase) == ST_RUN |-> $stable(boot_mode_capture))
        else $error("capture changed while running");

    AST_PULL_EXCLUSIVE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (boot_pulldown_en & boot_pullup_en) == PULL_UP_NONE)
        else $error("pullup and pulldown both on");

    AST_RELEASE_PULLDOWN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_por_exit |-> boot_pulldown_en == PULL_DOWN_ALL && boot_pullup_en == PULL_UP_NONE)
        else $error("boot pins not pulled down after release");

    AST_RUN_PULLS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !in_power_on(st_reg.phase) |-> boot_pullup_en == ~st_reg.pull_direction_select)
        else $error("pullups disagree with select outside power-on");

    AST_CAPTURE_AT_EXIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $changed(boot_mode_capture) |-> s_por_exit)
        else $error("capture changed away from power-on exit");

    AST_VALID_AT_EXIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(capture_valid) |-> s_por_exit)
        else $error("capture valid rose away from power-on exit");

    AST_EXIT_LEAVES_RESET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_por_exit |-> !in_reset && other_pulldown_en == {OTHER_W{1'b0}})
        else $error("reset outputs stuck after power-on exit");

    AST_ENTRY_QUALIFY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_por_entry |-> st_reg.qualified == !$past(rin.test_rst))
        else $error("power-on entry qualified wrongly");

    AST_TRST_DISQUALIFY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_POR && rin.test_rst |=> !st_reg.qualified)
        else $error("test reset did not disqualify capture");

    AST_UNQUALIFIED_EXIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_POR && rin.por_n && !st_reg.qualified
        |=> $stable(boot_mode_capture) && $stable(capture_valid))
        else $error("unqualified power-on exit captured");

    AST_WARM_ENTRY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_RUN && rin.por_n && !rin.warm_n |=> st_reg.phase == ST_WARM)
        else $error("warm reset not entered");

    AST_POR_OVER_WARM: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_WARM && !rin.por_n |=> st_reg.phase == ST_POR && $stable(boot_mode_capture))
        else $error("power-on did not override warm reset");

    AST_WARM_EXIT_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_warm_exit |-> $stable(boot_mode_capture) && $stable(capture_valid))
        else $error("warm exit altered capture");

    AST_OTHER_WARM: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_WARM |-> other_pulldown_en == {OTHER_W{1'b1}})
        else $error("other pins not pulled down in warm reset");

    AST_OTHER_RUN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !in_reset |-> other_pulldown_en == {OTHER_W{1'b0}})
        else $error("other pulldowns left on while running");

    AST_REENTRY_SELECT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_por_entry |-> st_reg.pull_direction_select == PULL_DOWN_ALL
        && boot_pulldown_en == PULL_DOWN_ALL)
        else $error("second power-on entered without pulldowns");

    AST_VALID_HELD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        capture_valid |=> capture_valid)
        else $error("capture valid dropped");

    AST_POR_HOLDS_CAPTURE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.phase == ST_POR && !rin.por_n |=> $stable(boot_mode_capture))
        else $error("capture changed inside power-on");
endmodule : boot_strap_latch
`default_nettype wire

// File: test/strap_source.sv
`timescale 1ns/1ps
`default_nettype none
module strap_source
    import boot_strap_pkg::*;
(
    input wire logic por_cmd,
    input wire logic warm_cmd,
    input wire logic trst_cmd,
    input wire logic [BOOT_W-1:0] strap,
    output logic por_req_n,
    output logic warm_req_n,
    output logic test_rst,
    output logic [BOOT_W-1:0] boot_pin
);
    assign por_req_n = ~por_cmd;
    assign warm_req_n = ~warm_cmd;
    // test reset stays low unless a scenario deliberately raises it
    assign test_rst = trst_cmd;
    // strong board straps override any internal pull
    assign boot_pin = strap;
endmodule : strap_source
`default_nettype wire

// File: test/boot_strap_latch_bench.sv
`timescale 1ns/1ps
`default_nettype none
module boot_strap_latch_bench
    import boot_strap_pkg::*;
;
    logic sys_clk = 0, arst_n = 0, por_cmd = 1, warm_cmd = 0, trst_cmd = 0, was_rst = 0;
    logic [BOOT_W-1:0] strap = 8'h00, exp_cap, pd, pu, cap;
    logic [OTHER_W-1:0] opd;
    logic por_req_n, warm_req_n, test_rst, valid, in_reset;
    logic [BOOT_W-1:0] boot_pin, q[$];
    int bad_count = 0, comparisons = 0, cycles = 0;
    always #4 sys_clk = ~sys_clk;
    strap_source u_src (.por_cmd(por_cmd), .warm_cmd(warm_cmd), .trst_cmd(trst_cmd),
        .strap(strap), .por_req_n(por_req_n), .warm_req_n(warm_req_n),
        .test_rst(test_rst), .boot_pin(boot_pin));
    boot_strap_latch u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .por_req_n(por_req_n),
        .warm_req_n(warm_req_n), .test_rst(test_rst), .boot_pin(boot_pin),
        .boot_pulldown_en(pd), .boot_pullup_en(pu), .other_pulldown_en(opd),
        .boot_mode_capture(cap), .capture_valid(valid), .in_reset(in_reset));
    task automatic wrap_up;
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic cmp_pull(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : cmp_pull
    task automatic cmp_capture(input logic [BOOT_W-1:0] got, input logic [BOOT_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: capture got %h want %h", $time, got, exp);
        end
    endtask : cmp_capture
    task automatic cmp_flag(input logic got, input logic exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %b want %b", $time, msg, got, exp);
        end
    endtask : cmp_flag
    task automatic wait_exit;
        int n;
        n = 0;
        while (in_reset !== 1'b0 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        if (in_reset !== 1'b0) begin
            bad_count++;
            $display("unexpected at %0t: reset phase never ended", $time);
        end
    endtask : wait_exit
    // kind 0: clean power-on, 1: warm reset, 2: power-on with test reset high
    task automatic pulse(input int kind);
        @(negedge sys_clk);
        strap = BOOT_W'($urandom);
        trst_cmd = (kind == 2);
        if (kind == 0) exp_cap = strap;
        q.push_back(exp_cap);
        if (kind == 1) warm_cmd = 1;
        else por_cmd = 1;
        repeat (8) @(negedge sys_clk);
        por_cmd = 0;
        warm_cmd = 0;
        wait_exit();
        repeat (3) @(negedge sys_clk);
        trst_cmd = 0;
    endtask : pulse
    always @(negedge sys_clk) begin
        if (arst_n) begin
            cmp_pull(pd, 8'hFF, "boot pulldown");
            cmp_pull(pu, 8'h00, "boot pullup");
            if (in_reset === 1'b1) cmp_pull(opd, 8'hFF, "other pulldown");
            else cmp_pull(opd, 8'h00, "other pulldown after reset");
            if (was_rst && in_reset === 1'b0 && q.size() > 0) begin
                cmp_capture(cap, q.pop_front());
                cmp_flag(valid, 1'b1, "capture valid");
            end else if (was_rst && in_reset === 1'b0) begin
                cmp_flag(1'b0, 1'b1, "reset exit with nothing expected");
            end
        end
        was_rst = (in_reset === 1'b1);
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'h6c7e58af));
        strap = BOOT_W'($urandom);
        exp_cap = strap;
        q.push_back(exp_cap);
        repeat (10) @(negedge sys_clk);
        arst_n = 1;
        repeat (3) @(negedge sys_clk);
        por_cmd = 0;
        wait_exit();
        pulse(1);
        pulse(2);
        pulse(0);
        repeat (12) pulse(int'($urandom % 3));
        cmp_flag(q.size() == 0, 1'b1, "captures left unseen");
        wrap_up();
    end
endmodule : boot_strap_latch_bench
`default_nettype wire
